/* design/wemi_pkg.sv */
package wemi_pkg;
  // Strap codes for input clock source
  localparam logic [1:0] STRAP_EXT = 2'h0;
  localparam logic [1:0] STRAP_CPU4 = 2'h1;
  localparam logic [1:0] STRAP_CPU6 = 2'h2;
  // Processor clock dividers (full and half periods in clk cycles)
  localparam int CPU4_DIV = 4;
  localparam int CPU6_DIV = 6;
  localparam logic [2:0] CPU4_HALF = 3'h2;
  localparam logic [2:0] CPU6_HALF = 3'h3;
  // Output divider codes
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  // Memory types of a space
  localparam logic [1:0] MEM_ASYNC = 2'h0;
  localparam logic [1:0] MEM_SDRAM = 2'h1;
  localparam logic [1:0] MEM_SYNC = 2'h2;
  // Register byte offsets
  localparam logic [3:0] REG_CLK_CTRL = 4'h0;
  localparam logic [3:0] REG_MEM_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // Field positions
  localparam int CLK_DIV_LSB = 0;
  localparam int MEM_TYPE_LSB = 0;
  localparam int READ_EN_SEL_BIT = 2;
  localparam int CKE_SW_BIT = 3;
  localparam int SDRAM_PRESENT_BIT = 4;
  localparam int SELF_REFRESH_BIT = 5;
  localparam int ST_STRAP_LSB = 0;
  localparam int ST_HOLD_ACK_BIT = 2;
  localparam int ST_HOLD_REQ_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  // Reset values
  localparam logic [1:0] CLK_DIV_RST = 2'h0;
  localparam logic [5:0] MEM_CTRL_RST = 6'h18;
  // Access length on the shared strobes, in clk cycles
  localparam logic [3:0] ACCESS_LEN = 4'h4;
  typedef enum logic [1:0] {
    WEMI_IDLE = 2'b00,
    WEMI_ACCESS = 2'b01,
    WEMI_HOLD_WAIT = 2'b11,
    WEMI_HELD = 2'b10
  } wemi_arb_e;
endpackage

/* design/wemi_clk_if.sv */
`timescale 1ns/1ps
interface wemi_clk_if;
  logic [1:0] div_sel;
  logic clk_src_tick;
  logic clk_full;
  logic clk_div;
  modport ctrl (output div_sel, input clk_src_tick, input clk_full, input clk_div);
  modport gen (input div_sel, output clk_src_tick, output clk_full, output clk_div);
endinterface

/* design/wemi_clk_gen.sv */
`timescale 1ns/1ps
module wemi_clk_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] strap_q,
  input wire logic ext_clk_s,
  wemi_clk_if.gen cif
);
  logic [2:0] pre_cnt_q;
  logic src_q;
  logic src_prev_q;
  logic [1:0] div_cnt_q;
  logic full_q;
  logic div_q;
  logic [2:0] half;
  logic src;
  logic rise;

  assign half = (strap_q == wemi_pkg::STRAP_CPU6) ? wemi_pkg::CPU6_HALF : wemi_pkg::CPU4_HALF;

  // Processor clock divided by four or six
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_q <= 3'h0;
      src_q <= 1'b0;
    end else if (pre_cnt_q == half - 3'h1) begin
      pre_cnt_q <= 3'h0;
      src_q <= ~src_q;
    end else begin
      pre_cnt_q <= pre_cnt_q + 3'h1;
    end
  end

  // External pin is the default source
  assign src = (strap_q == wemi_pkg::STRAP_CPU4 || strap_q == wemi_pkg::STRAP_CPU6) ?
               src_q : ext_clk_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) src_prev_q <= 1'b0;
    else src_prev_q <= src;
  end
  assign rise = src & ~src_prev_q;
  assign cif.clk_src_tick = rise;

  // Full-rate copy of the selected source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) full_q <= 1'b0;
    else full_q <= src;
  end
  assign cif.clk_full = full_q;

  // Divider counts source edges; by-1 just follows the source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 2'h0;
      div_q <= 1'b0;
    end else begin
      if (rise) div_cnt_q <= div_cnt_q + 2'h1;
      unique case (cif.div_sel)
        wemi_pkg::DIV_BY2: if (rise) div_q <= ~div_q;
        wemi_pkg::DIV_BY4: if (rise && div_cnt_q[0]) div_q <= ~div_q;
        default: div_q <= src;
      endcase
    end
  end
  assign cif.clk_div = div_q;
endmodule

/* design/wemi_top.sv */
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module wemi_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] clk_src_strap_pins,
  input wire logic ext_if_clk_in,
  input wire logic acc_req,
  input wire logic acc_write,
  output logic acc_done,
  output logic ext_if_clk_out_full,
  output logic ext_if_clk_out_div,
  output logic strobe_rd_o,
  output logic strobe_rd_oe,
  output logic strobe_oe_o,
  output logic strobe_oe_oe,
  output logic strobe_we_o,
  output logic strobe_we_oe,
  output logic sdram_clk_en,
  output logic sdram_clk_en_oe,
  input wire logic bus_hold_req,
  output logic bus_hold_ack,
  output logic pending_access_req
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] strap_m_q;
  logic [1:0] strap_s_q;
  logic [1:0] strap_q;
  logic strap_done_q;
  logic ext_m_q;
  logic ext_s_q;
  logic hold_m_q;
  logic hold_s_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_m_q <= 2'h0;
      strap_s_q <= 2'h0;
      ext_m_q <= 1'b0;
      ext_s_q <= 1'b0;
      hold_m_q <= 1'b0;
      hold_s_q <= 1'b0;
    end else begin
      strap_m_q <= clk_src_strap_pins;
      strap_s_q <= strap_m_q;
      ext_m_q <= ext_if_clk_in;
      ext_s_q <= ext_m_q;
      hold_m_q <= bus_hold_req;
      hold_s_q <= hold_m_q;
    end
  end

  // Straps caught once after release; later pin changes are ignored
  logic [1:0] strap_wait_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_q <= wemi_pkg::STRAP_EXT;
      strap_done_q <= 1'b0;
      strap_wait_q <= 2'h0;
    end else if (!strap_done_q) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h2) begin
        strap_q <= strap_s_q;
        strap_done_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [1:0] clk_div_q;
  logic [5:0] mem_ctrl_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] status;
  logic wb_req;
  wemi_pkg::wemi_arb_e arb_q;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_div_q <= wemi_pkg::CLK_DIV_RST;
      mem_ctrl_q <= wemi_pkg::MEM_CTRL_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == wemi_pkg::REG_CLK_CTRL) begin
        clk_div_q <= wb_dat_i[wemi_pkg::CLK_DIV_LSB +: 2];
      end
      if (wb_adr_i == wemi_pkg::REG_MEM_CTRL) begin
        mem_ctrl_q <= wb_dat_i[5:0];
      end
    end
  end

  always_comb begin
    status = 32'h0;
    status[wemi_pkg::ST_STRAP_LSB +: 2] = strap_q;
    status[wemi_pkg::ST_HOLD_ACK_BIT] = (arb_q == wemi_pkg::WEMI_HELD);
    status[wemi_pkg::ST_HOLD_REQ_BIT] = hold_s_q;
    status[wemi_pkg::ST_BUSY_BIT] = (arb_q == wemi_pkg::WEMI_ACCESS);
  end

  // One wait-free answer per request; unmapped reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          wemi_pkg::REG_CLK_CTRL: rdat_q <= {30'h0, clk_div_q};
          wemi_pkg::REG_MEM_CTRL: rdat_q <= {26'h0, mem_ctrl_q};
          wemi_pkg::REG_STATUS: rdat_q <= status;
          default: rdat_q <= 32'h0;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ------------------------------------------------------------
  // Clock generation
  // ------------------------------------------------------------
  wemi_clk_if cif ();
  assign cif.div_sel = clk_div_q;

  wemi_clk_gen u_clk_gen (
    .clk(clk),
    .rst(rst),
    .strap_q(strap_q),
    .ext_clk_s(ext_s_q),
    .cif(cif)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_if_clk_out_full <= 1'b0;
      ext_if_clk_out_div <= 1'b0;
    end else begin
      ext_if_clk_out_full <= cif.clk_full;
      ext_if_clk_out_div <= cif.clk_div;
    end
  end

  // ------------------------------------------------------------
  // Access and arbitration
  // ------------------------------------------------------------
  logic [3:0] acc_cnt_q;
  logic acc_wr_q;
  logic pend_q;
  logic [1:0] mem_type;
  logic rd_sel;

  assign mem_type = mem_ctrl_q[wemi_pkg::MEM_TYPE_LSB +: 2];
  assign rd_sel = mem_ctrl_q[wemi_pkg::READ_EN_SEL_BIT];

  // Request waits while held, so it stays pending
  // A request in the cycle an access starts must not be lost, so set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pend_q <= 1'b0;
    else if (acc_req) pend_q <= 1'b1;
    else if (arb_q == wemi_pkg::WEMI_IDLE && pend_q && !hold_s_q) pend_q <= 1'b0;
  end

  // Hold has priority only between accesses; a running one finishes first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arb_q <= wemi_pkg::WEMI_IDLE;
      acc_cnt_q <= 4'h0;
      acc_wr_q <= 1'b0;
    end else begin
      unique case (arb_q)
        wemi_pkg::WEMI_IDLE: begin
          if (hold_s_q) begin
            arb_q <= wemi_pkg::WEMI_HOLD_WAIT;
          end else if (pend_q) begin
            arb_q <= wemi_pkg::WEMI_ACCESS;
            acc_cnt_q <= wemi_pkg::ACCESS_LEN;
            acc_wr_q <= acc_write;
          end
        end
        wemi_pkg::WEMI_ACCESS: begin
          acc_cnt_q <= acc_cnt_q - 4'h1;
          if (acc_cnt_q == 4'h1) arb_q <= wemi_pkg::WEMI_IDLE;
        end
        wemi_pkg::WEMI_HOLD_WAIT: begin
          // Outputs float one cycle before acknowledge
          arb_q <= hold_s_q ? wemi_pkg::WEMI_HELD : wemi_pkg::WEMI_IDLE;
        end
        wemi_pkg::WEMI_HELD: begin
          if (!hold_s_q) arb_q <= wemi_pkg::WEMI_IDLE;
        end
      endcase
    end
  end

  logic active;
  logic drive;
  assign active = (arb_q == wemi_pkg::WEMI_ACCESS);
  assign drive = (arb_q == wemi_pkg::WEMI_IDLE) || active;

  // Strobes active low; idle high while driven
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_rd_o <= 1'b1;
      strobe_oe_o <= 1'b1;
      strobe_we_o <= 1'b1;
      strobe_rd_oe <= 1'b0;
      strobe_oe_oe <= 1'b0;
      strobe_we_oe <= 1'b0;
      acc_done <= 1'b0;
    end else begin
      strobe_rd_o <= 1'b1;
      strobe_oe_o <= 1'b1;
      strobe_we_o <= 1'b1;
      strobe_rd_oe <= drive;
      strobe_oe_oe <= drive;
      strobe_we_oe <= drive;
      acc_done <= active && acc_cnt_q == 4'h1;
      if (active) begin
        unique case (mem_type)
          wemi_pkg::MEM_SDRAM: begin
            // Row strobe opens, column strobe on last cycle
            strobe_oe_o <= (acc_cnt_q != wemi_pkg::ACCESS_LEN);
            strobe_rd_o <= (acc_cnt_q != 4'h1);
            strobe_we_o <= ~(acc_wr_q && acc_cnt_q == 4'h1);
          end
          wemi_pkg::MEM_SYNC: begin
            if (rd_sel) strobe_rd_o <= acc_wr_q;
            else strobe_rd_o <= (acc_cnt_q != wemi_pkg::ACCESS_LEN);
            strobe_oe_o <= acc_wr_q;
            strobe_we_o <= ~acc_wr_q;
          end
          default: begin
            strobe_rd_o <= acc_wr_q;
            strobe_oe_o <= acc_wr_q;
            strobe_we_o <= ~acc_wr_q;
          end
        endcase
      end
    end
  end

  // Clock enable: self-refresh or general output, floated with the strobes during hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdram_clk_en <= 1'b1;
      sdram_clk_en_oe <= 1'b1;
      bus_hold_ack <= 1'b0;
      pending_access_req <= 1'b0;
    end else begin
      if (mem_ctrl_q[wemi_pkg::SDRAM_PRESENT_BIT]) begin
        sdram_clk_en <= ~mem_ctrl_q[wemi_pkg::SELF_REFRESH_BIT];
      end else begin
        sdram_clk_en <= mem_ctrl_q[wemi_pkg::CKE_SW_BIT];
      end
      sdram_clk_en_oe <= drive;
      bus_hold_ack <= (arb_q == wemi_pkg::WEMI_HELD) && hold_s_q;
      pending_access_req <= pend_q || active;
    end
  end
endmodule

/* test/wemi_host.sv */
`timescale 1ns/1ps
module wemi_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic want,
  output logic bus_hold_req
);
  // Request kept up for the whole tenure
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_hold_req <= 1'h0;
    end else begin
      bus_hold_req <= want;
    end
  end
endmodule

/* test/wemi_sva.sv */
`timescale 1ns/1ps
module wemi_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic acc_done,
  input wire logic strobe_rd_oe,
  input wire logic strobe_oe_oe,
  input wire logic strobe_we_oe,
  input wire logic bus_hold_req,
  input wire logic bus_hold_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_done_pulse: assert property (acc_done |=> !acc_done)
    else $error("done too long");
  a_hold_float: assert property (bus_hold_ack |-> !(strobe_rd_oe || strobe_oe_oe || strobe_we_oe))
    else $error("strobe driven in hold");
  a_hold_cause: assert property ($rose(bus_hold_ack) |-> $past(bus_hold_req, 3))
    else $error("ack without request");
  a_hold_grant: assert property (bus_hold_req [*8] |-> ##[0:8] bus_hold_ack)
    else $error("hold not granted");
  a_hold_release: assert property (!bus_hold_req [*5] |-> !bus_hold_ack)
    else $error("ack kept after release");
  a_done_not_held: assert property (acc_done |-> !bus_hold_ack)
    else $error("access in hold");
endmodule
bind wemi_top wemi_sva u_sva (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .acc_done,
  .strobe_rd_oe, .strobe_oe_oe, .strobe_we_oe, .bus_hold_req, .bus_hold_ack);

/* test/tb_wemi_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_wemi_top;
  logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, acc_req, acc_write, want;
  logic ext_if_clk_in = 1'h0;
  logic ext_run = 1'h0;
  int ext_k = 0;
  localparam int EXT_HALF = 5;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat, v;
  logic [1:0] clk_src_strap_pins;
  logic wb_ack_o, acc_done, ext_if_clk_out_full, ext_if_clk_out_div, strobe_rd_o;
  logic strobe_rd_oe, strobe_oe_o, strobe_oe_oe, strobe_we_o, strobe_we_oe;
  logic sdram_clk_en, sdram_clk_en_oe, bus_hold_req, bus_hold_ack, pending_access_req;
  logic [2:0] lo;
  int err_count, check_count, seed, p, i, t, r, w, n;
  int regs[3];
  wemi_top uut (.*);
  wemi_host u_host (.clk(clk), .rst(rst), .want(want), .bus_hold_req(bus_hold_req));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // External source clock, still until a test needs it
  always @(posedge clk) begin
    if (ext_run && ext_k == EXT_HALF - 1) begin
      ext_k <= 0;
      ext_if_clk_in <= ~ext_if_clk_in;
    end else if (ext_run) begin
      ext_k <= ext_k + 1;
    end
  end
  // ----
  // Tasks
  // ----
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'h1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (wb_ack_o !== 1'h1) err_count++;
    rdat = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // Period of an output clock in clk cycles; first rises absorb a divider change
  task automatic per(input int sel, output int c);
    logic s, prv;
    s = 1'h1;
    for (int k = 0; k < 3; k++) begin
      c = 0;
      do begin
        prv = s;
        @(posedge clk);
        s = sel ? ext_if_clk_out_div : ext_if_clk_out_full;
        c++;
      end while (!(s && !prv) && c < 64);
    end
  endtask
  task automatic acc(input logic wr);
    int k;
    k = 0;
    lo = 3'h0;
    @(posedge clk);
    acc_req <= 1'h1;
    acc_write <= wr;
    @(posedge clk);
    acc_req <= 1'h0;
    while (acc_done !== 1'h1 && k < 20) begin
      @(posedge clk);
      k++;
      lo |= {strobe_rd_oe & ~strobe_rd_o, strobe_oe_oe & ~strobe_oe_o,
             strobe_we_oe & ~strobe_we_o};
    end
    if (acc_done !== 1'h1) err_count++;
  endtask
  // Lows seen on {read strobe, output enable, write enable}
  function automatic logic [2:0] exp_lo(input int ty, input int rs, input int wr);
    if (wr == 0) return 3'h6;
    if (ty == 1) return 3'h7;
    if (ty == 2 && rs == 0) return 3'h5;
    return 3'h1;
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    seed = 32'h3FD7;
    {rst, wb_sel_i} = {1'h1, 4'hF};
    {wb_cyc_i, wb_stb_i, wb_we_i, acc_req, acc_write, want} = 6'h00;
    {wb_adr_i, wb_dat_i} = 36'h0;
    clk_src_strap_pins = wemi_pkg::STRAP_CPU4;
    regs = '{int'(wemi_pkg::CLK_DIV_RST), int'(wemi_pkg::MEM_CTRL_RST), 0};
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    wb(1'h0, wemi_pkg::REG_CLK_CTRL, 32'h0);
    `CHK("clk_ctrl", regs[0], rdat)
    wb(1'h0, wemi_pkg::REG_MEM_CTRL, 32'h0);
    `CHK("mem_ctrl", regs[1], rdat)
    wb(1'h0, wemi_pkg::REG_STATUS, 32'h0);
    `CHK("strap", wemi_pkg::STRAP_CPU4, rdat[1:0])
    wb(1'h0, 4'hC, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    per(0, p);
    `CHK("full_period", wemi_pkg::CPU4_DIV, p)
    for (i = 0; i < 3; i++) begin
      wb(1'h1, wemi_pkg::REG_CLK_CTRL, 32'(i));
      per(1, p);
      `CHK("div_period", wemi_pkg::CPU4_DIV << i, p)
    end
    $display("clock test done");
    for (t = 0; t < 3; t++) for (r = 0; r < 2; r++) for (w = 0; w < 2; w++) begin
      wb(1'h1, wemi_pkg::REG_MEM_CTRL, 32'(t + 4 * r) | 32'h18);
      acc(w[0]);
      `CHK("strobes", exp_lo(t, r, w), lo)
    end
    $display("strobe test done");
    // Without SDRAM the enable follows a random software bit
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wb(1'h1, wemi_pkg::REG_MEM_CTRL, {28'h0, v[0], 3'h0});
      repeat (3) @(posedge clk);
      `CHK("cke_sw", {1'h1, v[0]}, {sdram_clk_en_oe, sdram_clk_en})
    end
    wb(1'h1, wemi_pkg::REG_MEM_CTRL, 32'h39);
    repeat (3) @(posedge clk);
    `CHK("cke_self_refresh", 1'h0, sdram_clk_en)
    wb(1'h1, wemi_pkg::REG_MEM_CTRL, 32'h19);
    repeat (3) @(posedge clk);
    `CHK("cke_run", 1'h1, sdram_clk_en)
    $display("cke test done");
    want <= 1'h1;
    n = 0;
    while (bus_hold_ack !== 1'h1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    `CHK("hold_ack", 1'h1, bus_hold_ack)
    `CHK("float", 3'h0, {strobe_rd_oe, strobe_oe_oe, strobe_we_oe})
    wb(1'h0, wemi_pkg::REG_STATUS, 32'h0);
    `CHK("status_held", 3'h3, rdat[wemi_pkg::ST_BUSY_BIT:wemi_pkg::ST_HOLD_ACK_BIT])
    acc_req <= 1'h1;
    @(posedge clk);
    acc_req <= 1'h0;
    repeat (3) @(posedge clk);
    `CHK("pending", 1'h1, pending_access_req)
    want <= 1'h0;
    n = 0;
    while (acc_done !== 1'h1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    `CHK("held_done", 1'h1, acc_done)
    $display("hold test done");
    // Straps are caught only after a reset, so each source gets its own
    clk_src_strap_pins <= wemi_pkg::STRAP_CPU6;
    rst <= 1'h1;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    wb(1'h0, wemi_pkg::REG_STATUS, 32'h0);
    `CHK("strap_cpu6", wemi_pkg::STRAP_CPU6, rdat[1:0])
    per(0, p);
    `CHK("full_cpu6", wemi_pkg::CPU6_DIV, p)
    clk_src_strap_pins <= 2'h3;
    ext_run <= 1'h1;
    rst <= 1'h1;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    wb(1'h0, wemi_pkg::REG_STATUS, 32'h0);
    `CHK("strap_none", 2'h3, rdat[1:0])
    per(0, p);
    `CHK("full_ext", 2 * EXT_HALF, p)
    wb(1'h1, wemi_pkg::REG_CLK_CTRL, 32'(wemi_pkg::DIV_BY4));
    per(1, p);
    `CHK("div_ext", 8 * EXT_HALF, p)
    $display("strap test done");
    finish_test;
  end
endmodule
